// ===== core/mies_exec.sv
// Execute stage for the instruction subset: jump, moves, OR, returns, rotate
`timescale 1ns/10ps
module mies_exec (
   input  wire logic                          sys_clk,       // System clock, 50 MHz
   input  wire logic                          rst,           // Asynchronous reset, active high
   input  wire logic                          instr_valid,   // Instruction word is present
   input  wire mies_pkg::mies_instr_t         instr,         // Decoded instruction word
   input  wire logic [mies_pkg::DATA_W-1:0]   mem_rd_data,   // Byte at instr.mem_addr, combinational
   input  wire logic [mies_pkg::PC_W-1:0]     stack_top,     // Return address at top of stack
   input  wire logic                          irq_pending,   // Interrupt request pending, same clock
   output logic                               instr_taken,   // Instruction executed last cycle
   output logic [mies_pkg::PC_W-1:0]          pc,            // Program counter
   output logic [mies_pkg::DATA_W-1:0]        acc,           // Accumulator
   output logic                               zero_flag,     // Zero status flag
   output logic                               master_irq_enable, // Global interrupt enable
   output mies_pkg::mies_mem_wr_t             mem_wr,        // Data memory write request
   output logic                               stack_pop,     // Pop pulse for the stack
   output logic                               irq_enter      // Interrupt entry pulse
);
   mies_pkg::mies_state_t             state_reg, state_next;
   logic [mies_pkg::PC_W-1:0]         pc_reg, pc_next;
   logic [mies_pkg::DATA_W-1:0]       acc_reg, acc_next;
   logic                              zero_reg, zero_next;
   logic                              mie_reg, mie_next;
   mies_pkg::mies_mem_wr_t            wr_reg, wr_next;
   logic                              pop_reg, pop_next;
   logic                              taken_reg, taken_next;
   logic                              irqe_reg, irqe_next;
   mies_pkg::mies_opcode_t            op;
   logic                              irq_take;
   logic                              exec_go;
   logic [mies_pkg::DATA_W-1:0]       src_byte;
   logic [mies_pkg::DATA_W-1:0]       or_mem;
   logic [mies_pkg::DATA_W-1:0]       or_imm;

   function automatic logic is_zero(input logic [mies_pkg::DATA_W-1:0] v);
      is_zero = (v == 8'h00); // RQ14
   endfunction

   function automatic logic [mies_pkg::DATA_W-1:0] rot_left(input logic [mies_pkg::DATA_W-1:0] v);
      rot_left = {v[mies_pkg::ROT_MSB-1:0], v[mies_pkg::ROT_MSB]}; // RQ13
   endfunction

   // Opcodes that restore the program counter from the stack
   function automatic logic is_return(input mies_pkg::mies_opcode_t o);
      case (o)
         mies_pkg::OP_SUB_EXIT, mies_pkg::OP_SUB_EXIT_IMM, mies_pkg::OP_INT_EXIT: begin
            is_return = 1'b1;
         end
         default: begin
            is_return = 1'b0;
         end
      endcase
   endfunction

   // Decode shared by the groups below
   always_comb begin
      op       = instr.opcode;
      irq_take = 1'b0;
      exec_go  = 1'b0;
      case (state_reg)
         mies_pkg::ST_EXEC: begin
            // Entry between instructions has priority over the word on instr
            irq_take = irq_pending && mie_reg;
            exec_go  = instr_valid && !irq_take;
         end
         mies_pkg::ST_IRQ: begin
            irq_take = irq_pending && mie_reg; // RQ12
         end
         default: begin
            irq_take = 1'b0;
         end
      endcase
   end

   // A store launched last cycle lands at this edge, so memory still shows the old byte
   always_comb begin
      if (wr_reg.wr_en && (wr_reg.addr == instr.mem_addr)) begin
         src_byte = wr_reg.data;
      end else begin
         src_byte = mem_rd_data;
      end
      or_mem = acc_reg | src_byte;
      or_imm = acc_reg | instr.literal;
   end

   // Control state: one dummy cycle after a change of flow, one check cycle after interrupt_exit
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         mies_pkg::ST_EXEC: begin
            if (irq_take) begin
               // Interrupt entry between instructions; one dummy cycle follows
               state_next = mies_pkg::ST_FLUSH;
            end else if (exec_go) begin
               if (op == mies_pkg::OP_INT_EXIT) begin
                  // Pending request is taken in the next cycle, the check cycle that also serves as the refill
                  state_next = mies_pkg::ST_IRQ; // RQ12
               end else if ((op == mies_pkg::OP_JUMP_ABS) || is_return(op)) begin
                  state_next = mies_pkg::ST_FLUSH; // RQ1
               end else begin
                  state_next = mies_pkg::ST_EXEC;
               end
            end else begin
               state_next = mies_pkg::ST_EXEC;
            end
         end
         mies_pkg::ST_FLUSH: begin
            // Dummy cycle while the new address is fetched
            state_next = mies_pkg::ST_EXEC; // RQ1
         end
         mies_pkg::ST_IRQ: begin
            if (irq_take) begin
               state_next = mies_pkg::ST_FLUSH; // RQ12
            end else begin
               state_next = mies_pkg::ST_EXEC;
            end
         end
         default: begin
            state_next = mies_pkg::ST_EXEC;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_reg <= mies_pkg::ST_EXEC;
      end else begin
         state_reg <= state_next;
      end
   end

   // Program counter: step, jump target, restored return address or interrupt vector
   always_comb begin
      pc_next = pc_reg;
      if (irq_take) begin
         pc_next = mies_pkg::IRQ_VECTOR; // RQ12
      end else if (exec_go) begin
         case (op)
            mies_pkg::OP_JUMP_ABS: begin
               pc_next = instr.target; // RQ1
            end
            mies_pkg::OP_SUB_EXIT: begin
               pc_next = stack_top; // RQ9
            end
            mies_pkg::OP_SUB_EXIT_IMM: begin
               pc_next = stack_top; // RQ10
            end
            mies_pkg::OP_INT_EXIT: begin
               pc_next = stack_top; // RQ11
            end
            default: begin
               // Every other opcode, idle_step included, moves on to the next word
               pc_next = pc_reg + 11'h001; // RQ5
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pc_reg <= mies_pkg::PC_RESET;
      end else begin
         pc_reg <= pc_next;
      end
   end

   // Accumulator and zero flag; only the OR forms touch the flag
   always_comb begin
      acc_next  = acc_reg;
      zero_next = zero_reg;
      if (exec_go) begin
         case (op)
            mies_pkg::OP_COPY_MEM_ACC: begin
               acc_next = src_byte; // RQ2
            end
            mies_pkg::OP_COPY_IMM_ACC: begin
               acc_next = instr.literal; // RQ3
            end
            mies_pkg::OP_OR_MEM_ACC: begin
               acc_next  = or_mem; // RQ6
               zero_next = is_zero(or_mem); // RQ6
            end
            mies_pkg::OP_OR_IMM_ACC: begin
               acc_next  = or_imm; // RQ7
               zero_next = is_zero(or_imm); // RQ7
            end
            mies_pkg::OP_OR_INTO_MEM: begin
               zero_next = is_zero(or_mem); // RQ8
            end
            mies_pkg::OP_SUB_EXIT_IMM: begin
               acc_next = instr.literal; // RQ10
            end
            default: begin
               acc_next  = acc_reg;
               zero_next = zero_reg;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         acc_reg  <= mies_pkg::ACC_RESET;
         zero_reg <= mies_pkg::ZERO_RESET;
      end else begin
         acc_reg  <= acc_next;
         zero_reg <= zero_next;
      end
   end

   // Master interrupt enable: set by interrupt_exit, cleared on entry to mask nesting
   always_comb begin
      mie_next = mie_reg;
      if (irq_take) begin
         mie_next = 1'b0;
      end else if (exec_go && (op == mies_pkg::OP_INT_EXIT)) begin
         mie_next = 1'b1; // RQ11
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         mie_reg <= mies_pkg::MIE_RESET;
      end else begin
         mie_reg <= mie_next;
      end
   end

   // Data memory write request, one cycle per store
   always_comb begin
      wr_next = '0;
      if (exec_go) begin
         case (op)
            mies_pkg::OP_COPY_ACC_MEM: begin
               wr_next = '{wr_en: 1'b1, addr: instr.mem_addr, data: acc_reg}; // RQ4
            end
            mies_pkg::OP_OR_INTO_MEM: begin
               wr_next = '{wr_en: 1'b1, addr: instr.mem_addr, data: or_mem}; // RQ8
            end
            mies_pkg::OP_ROTATE_LEFT: begin
               wr_next = '{wr_en: 1'b1, addr: instr.mem_addr, data: rot_left(src_byte)}; // RQ13
            end
            default: begin
               wr_next = '0;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         wr_reg <= '0;
      end else begin
         wr_reg <= wr_next;
      end
   end

   // Executed-instruction pulse for the fetch path
   always_comb begin
      taken_next = exec_go;
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         taken_reg <= 1'b0;
      end else begin
         taken_reg <= taken_next;
      end
   end

   // Pop pulse for the return stack
   always_comb begin
      pop_next = exec_go && is_return(op); // RQ9 RQ10 RQ11
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pop_reg <= 1'b0;
      end else begin
         pop_reg <= pop_next;
      end
   end

   // Interrupt entry pulse for the interrupt controller
   always_comb begin
      irqe_next = irq_take; // RQ12
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         irqe_reg <= 1'b0;
      end else begin
         irqe_reg <= irqe_next;
      end
   end

   assign pc                = pc_reg;
   assign acc               = acc_reg;
   assign zero_flag         = zero_reg;
   assign master_irq_enable = mie_reg;
   assign mem_wr            = wr_reg;
   assign stack_pop         = pop_reg;
   assign instr_taken       = taken_reg;
   assign irq_enter         = irqe_reg;
endmodule

// ===== core/mies_pkg.sv
// Package of constants, types and opcodes for the instruction execution subset
// What this block does
// RQ1 - A jump_absolute loads the program counter from the instruction address and takes two cycles with a dummy cycle, flags unchanged.
// RQ2 - A copy_operand from memory copies the addressed data byte into the accumulator, flags unchanged.
// RQ3 - A copy_operand immediate loads the literal into the accumulator, flags unchanged.
// RQ4 - A copy_operand to memory writes the accumulator to the addressed data byte, flags unchanged.
// RQ5 - An idle_step changes nothing and moves on to the next instruction.
// RQ6 - OR with memory puts accumulator OR memory byte in the accumulator and updates only the zero flag.
// RQ7 - OR with literal puts accumulator OR literal in the accumulator and updates only the zero flag.
// RQ8 - An or_into_memory writes accumulator OR memory byte back to memory and updates only the zero flag.
// RQ9 - A subroutine_exit pops the return address into the program counter and resumes there, flags unchanged.
// RQ10 - A subroutine_exit with literal pops the program counter and loads the literal into the accumulator, flags unchanged.
// RQ11 - An interrupt_exit pops the program counter and sets master_irq_enable to one, flags unchanged.
// RQ12 - If an interrupt is pending at interrupt_exit, that interrupt is serviced before the main program resumes.
// RQ13 - A rotate_left moves the memory byte left one place with bit 7 into bit 0, writes it back and alters no flag.
// RQ14 - Where the zero flag is updated it is set when the 8-bit result is zero and cleared otherwise.
package mies_pkg;
   localparam int PC_W   = 11;
   localparam int DATA_W = 8;
   localparam int ADDR_W = 8;
   localparam int OPC_W  = 4;

   localparam logic [PC_W-1:0]   PC_RESET  = 11'h000;
   localparam logic [PC_W-1:0]   IRQ_VECTOR = 11'h004;
   localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
   localparam logic              ZERO_RESET = 1'b0;
   localparam logic              MIE_RESET = 1'b0;
   localparam int                ROT_MSB   = 7;

   typedef enum logic [OPC_W-1:0] {
      OP_IDLE_STEP    = 4'h0,
      OP_JUMP_ABS     = 4'h1,
      OP_COPY_MEM_ACC = 4'h2,
      OP_COPY_IMM_ACC = 4'h3,
      OP_COPY_ACC_MEM = 4'h4,
      OP_OR_MEM_ACC   = 4'h5,
      OP_OR_IMM_ACC   = 4'h6,
      OP_OR_INTO_MEM  = 4'h7,
      OP_SUB_EXIT     = 4'h8,
      OP_SUB_EXIT_IMM = 4'h9,
      OP_INT_EXIT     = 4'hA,
      OP_ROTATE_LEFT  = 4'hB
   } mies_opcode_t;

   // Decoded instruction word as presented by the fetch path
   typedef struct packed {
      mies_opcode_t      opcode;
      logic [PC_W-1:0]   target;
      logic [ADDR_W-1:0] mem_addr;
      logic [DATA_W-1:0] literal;
   } mies_instr_t;

   // Data memory write request
   typedef struct packed {
      logic              wr_en;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } mies_mem_wr_t;

   typedef enum logic [2:0] {
      ST_EXEC  = 3'b001,
      ST_FLUSH = 3'b010,
      ST_IRQ   = 3'b100
   } mies_state_t;
endpackage

// ===== sim/mies_exec_monitor.sv
// Port checker for the execute stage
`timescale 1ns/10ps
module mies_exec_monitor (
   input wire logic                        sys_clk,           // Clock
   input wire logic                        rst,               // Reset
   input wire mies_pkg::mies_instr_t       instr,             // Instruction
   input wire logic [mies_pkg::DATA_W-1:0] mem_rd_data,       // Memory byte
   input wire logic [mies_pkg::PC_W-1:0]   stack_top,         // Stack top
   input wire logic                        irq_pending,       // Pending request
   input wire logic                        instr_taken,       // Executed
   input wire logic [mies_pkg::PC_W-1:0]   pc,                // Program counter
   input wire logic [mies_pkg::DATA_W-1:0] acc,               // Accumulator
   input wire logic                        zero_flag,         // Zero flag
   input wire logic                        master_irq_enable, // Global enable
   input wire mies_pkg::mies_mem_wr_t      mem_wr,            // Write request
   input wire logic                        stack_pop,         // Pop pulse
   input wire logic                        irq_enter          // Entry pulse
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   logic [3:0] op_q;
   always_ff @(posedge sys_clk) op_q <= instr.opcode;
   // Byte the instruction sees: a store still in flight to the same address wins
   logic [7:0] eff_byte;
   assign eff_byte = (mem_wr.wr_en && (mem_wr.addr == instr.mem_addr)) ? mem_wr.data : mem_rd_data;
   property p_jump; instr_taken && op_q == 4'h1 |-> pc == $past(instr.target) ##1 !instr_taken; endproperty
   a_jump: assert property (p_jump) else $error("jump target or dummy cycle wrong");
   property p_ld; instr_taken && op_q == 4'h2 |-> acc == $past(eff_byte) && $stable(zero_flag); endproperty
   a_ld: assert property (p_ld) else $error("memory to accumulator wrong");
   property p_imm; instr_taken && op_q == 4'h3 |-> acc == $past(instr.literal) && $stable(zero_flag); endproperty
   a_imm: assert property (p_imm) else $error("literal to accumulator wrong");
   property p_st; instr_taken && op_q == 4'h4 |-> mem_wr.wr_en && mem_wr.data == $past(acc); endproperty
   a_st: assert property (p_st) else $error("accumulator store wrong");
   property p_idle; instr_taken && op_q == 4'h0 |-> $stable(acc) && !mem_wr.wr_en && !stack_pop; endproperty
   a_idle: assert property (p_idle) else $error("idle step changed state");
   property p_orm; instr_taken && op_q == 4'h5 |-> acc == ($past(acc) | $past(eff_byte)) && zero_flag == (acc == 8'h00);
   endproperty
   a_orm: assert property (p_orm) else $error("or with memory wrong");
   property p_ori; instr_taken && op_q == 4'h6 |-> acc == ($past(acc) | $past(instr.literal)) && zero_flag == (acc == 8'h00);
   endproperty
   a_ori: assert property (p_ori) else $error("or with literal wrong");
   property p_orin; instr_taken && op_q == 4'h7 |-> mem_wr.wr_en && mem_wr.data == ($past(acc) | $past(eff_byte))
      && $stable(acc) && zero_flag == (mem_wr.data == 8'h00);
   endproperty
   a_orin: assert property (p_orin) else $error("or into memory wrong");
   property p_ret; instr_taken && op_q == 4'h8 |-> pc == $past(stack_top) && stack_pop && $stable(zero_flag); endproperty
   a_ret: assert property (p_ret) else $error("return wrong");
   property p_rimm; instr_taken && op_q == 4'h9 |-> pc == $past(stack_top) && acc == $past(instr.literal)
      && stack_pop && $stable(zero_flag); endproperty
   a_rimm: assert property (p_rimm) else $error("return with literal wrong");
   property p_interrupt_exit; instr_taken && op_q == 4'hA |-> pc == $past(stack_top) && master_irq_enable; endproperty
   a_interrupt_exit: assert property (p_interrupt_exit) else $error("interrupt return wrong");
   property p_irq; instr_taken && op_q == 4'hA && irq_pending |-> ##[1:2] irq_enter && pc == mies_pkg::IRQ_VECTOR;
   endproperty
   a_irq: assert property (p_irq) else $error("pending interrupt not entered");
   property p_rot; instr_taken && op_q == 4'hB |-> mem_wr.wr_en && mem_wr.data == 8'({$past(eff_byte), $past(eff_byte)} >> 7);
   endproperty
   a_rot: assert property (p_rot) else $error("rotate result wrong");
endmodule
bind mies_exec mies_exec_monitor u_mies_exec_monitor (.sys_clk, .rst, .instr, .mem_rd_data, .stack_top, .irq_pending,
   .instr_taken, .pc, .acc, .zero_flag, .master_irq_enable, .mem_wr, .stack_pop, .irq_enter);

// ===== sim/mies_mem_model.sv
// Data memory and return stack model
`timescale 1ns/10ps
module mies_mem_model (
   input  wire logic                        sys_clk,     // Clock
   input  wire logic [mies_pkg::ADDR_W-1:0] rd_addr,     // Read address
   input  wire mies_pkg::mies_mem_wr_t      mem_wr,      // Write request
   input  wire logic                        stack_pop,   // Pop pulse
   input  wire logic                        push_en,     // Push strobe
   input  wire logic [mies_pkg::PC_W-1:0]   push_addr,   // Pushed address
   output logic      [mies_pkg::DATA_W-1:0] mem_rd_data, // Read byte
   output logic      [mies_pkg::PC_W-1:0]   stack_top    // Top of stack
);
   logic [7:0]  mem [256];
   logic [10:0] stk [4];
   logic [1:0]  sp = 2'h0;
   assign mem_rd_data = mem[rd_addr];
   assign stack_top = stk[sp-2'h1];
   always @(posedge sys_clk) begin
      if (mem_wr.wr_en)
         mem[mem_wr.addr] <= mem_wr.data;
      if (push_en) begin
         stk[sp] <= push_addr;
         sp <= sp + 2'h1;
      end else if (stack_pop)
         sp <= sp - 2'h1;
   end
endmodule

// ===== sim/test_mies_exec.sv
// Self-checking bench for the execute stage
`timescale 1ns/10ps
module test_mies_exec;
   logic                  sys_clk = 1'b0, rst = 1'b1, instr_valid = 1'b0, irq_pending = 1'b0, push_en = 1'b0;
   mies_pkg::mies_instr_t instr = '0;
   logic [10:0]           push_addr = 11'h000, stack_top, pc;
   logic [7:0]            mem_rd_data, acc;
   logic                  instr_taken, zero_flag, master_irq_enable, stack_pop, irq_enter, seen;
   mies_pkg::mies_mem_wr_t mem_wr;
   int error_cnt = 0, n_compared = 0, cycles = 0;
   always #10 sys_clk = ~sys_clk;
   mies_exec u_mies_exec (.sys_clk, .rst, .instr_valid, .instr, .mem_rd_data, .stack_top, .irq_pending, .instr_taken,
      .pc, .acc, .zero_flag, .master_irq_enable, .mem_wr, .stack_pop, .irq_enter);
   mies_mem_model u_mies_mem_model (.sys_clk, .rd_addr(instr.mem_addr), .mem_wr, .stack_pop, .push_en, .push_addr,
      .mem_rd_data, .stack_top);
   task automatic stop_test;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 2000) begin
         error_cnt++;
         stop_test();
      end
   end
   task automatic chk(input string what, input logic [16:0] exp, input logic [16:0] got);
      n_compared++;
      if (got !== exp) begin
         $display("ERROR %s expected %h seen %h", what, exp, got);
         error_cnt++;
      end
   endtask
   task automatic go(input mies_pkg::mies_opcode_t op, input logic [7:0] ad, lit, input logic [10:0] tg, input logic tk);
      instr_valid = 1'b1;
      instr = {op, tg, ad, lit};
      @(posedge sys_clk);
      #1;
      chk("instr_taken", {16'h0, tk}, {16'h0, instr_taken});
   endtask
   task automatic quiet;
      instr_valid = 1'b0;
      @(posedge sys_clk);
      #1;
   endtask
   task automatic push(input logic [10:0] a);
      push_en = 1'b1;
      push_addr = a;
      @(posedge sys_clk);
      #1;
      push_en = 1'b0;
   endtask
   task automatic t_data;
      go(mies_pkg::OP_COPY_IMM_ACC, 8'h00, 8'h5A, 11'h000, 1'b1);
      chk("acc", 17'h0005A, {9'h0, acc});
      go(mies_pkg::OP_COPY_ACC_MEM, 8'h10, 8'h00, 11'h000, 1'b1);
      chk("mem_wr", 17'h1105A, mem_wr);
      go(mies_pkg::OP_COPY_IMM_ACC, 8'h00, 8'h00, 11'h000, 1'b1);
      go(mies_pkg::OP_COPY_MEM_ACC, 8'h10, 8'h00, 11'h000, 1'b1);
      chk("acc", 17'h0005A, {9'h0, acc});
      go(mies_pkg::OP_IDLE_STEP, 8'h00, 8'h00, 11'h000, 1'b1);
      chk("wr_en", 17'h0, {16'h0, mem_wr.wr_en});
      go(mies_pkg::mies_opcode_t'(4'hC), 8'h10, 8'h33, 11'h000, 1'b1);
      chk("acc", 17'h0005A, {9'h0, acc});
      go(mies_pkg::OP_OR_IMM_ACC, 8'h00, 8'h00, 11'h000, 1'b1);
      chk("zero", 17'h0, {16'h0, zero_flag});
      go(mies_pkg::OP_COPY_IMM_ACC, 8'h00, 8'h00, 11'h000, 1'b1);
      go(mies_pkg::OP_OR_IMM_ACC, 8'h00, 8'h00, 11'h000, 1'b1);
      chk("zero", 17'h1, {16'h0, zero_flag});
      go(mies_pkg::OP_OR_IMM_ACC, 8'h00, 8'h81, 11'h000, 1'b1);
      go(mies_pkg::OP_OR_MEM_ACC, 8'h10, 8'h00, 11'h000, 1'b1);
      chk("acc", 17'h000DB, {9'h0, acc});
      go(mies_pkg::OP_OR_INTO_MEM, 8'h10, 8'h00, 11'h000, 1'b1);
      chk("mem_wr", 17'h110DB, mem_wr);
      go(mies_pkg::OP_ROTATE_LEFT, 8'h10, 8'h00, 11'h000, 1'b1);
      chk("mem_wr", 17'h110B7, mem_wr);
      go(mies_pkg::OP_ROTATE_LEFT, 8'h10, 8'h00, 11'h000, 1'b1);
      chk("mem_wr", 17'h1106F, mem_wr);
      quiet();
      $display("t_data done");
   endtask
   task automatic t_flow;
      go(mies_pkg::OP_JUMP_ABS, 8'h00, 8'h00, 11'h3C5, 1'b1);
      chk("pc", 17'h003C5, {6'h0, pc});
      go(mies_pkg::OP_IDLE_STEP, 8'h00, 8'h00, 11'h000, 1'b0);
      go(mies_pkg::OP_IDLE_STEP, 8'h00, 8'h00, 11'h000, 1'b1);
      chk("pc", 17'h003C6, {6'h0, pc});
      quiet();
      push(11'h0AB);
      go(mies_pkg::OP_SUB_EXIT_IMM, 8'h00, 8'h77, 11'h000, 1'b1);
      chk("pc", 17'h000AB, {6'h0, pc});
      chk("acc", 17'h00077, {9'h0, acc});
      quiet();
      push(11'h066);
      irq_pending = 1'b1;
      go(mies_pkg::OP_INT_EXIT, 8'h00, 8'h00, 11'h000, 1'b1);
      chk("pc", 17'h00066, {6'h0, pc});
      chk("mie", 17'h1, {16'h0, master_irq_enable});
      seen = 1'b0;
      repeat (2) begin
         quiet();
         if (irq_enter === 1'b1)
            seen = 1'b1;
      end
      irq_pending = 1'b0;
      chk("irq_enter", 17'h1, {16'h0, seen});
      chk("pc", 17'h00004, {6'h0, pc});
      push(11'h155);
      go(mies_pkg::OP_SUB_EXIT, 8'h00, 8'h00, 11'h000, 1'b1);
      chk("pc", 17'h00155, {6'h0, pc});
      chk("stack_pop", 17'h1, {16'h0, stack_pop});
      quiet();
      $display("t_flow done");
   endtask
   initial begin
      repeat (6) @(posedge sys_clk);
      #1;
      rst = 1'b0;
      t_data();
      t_flow();
      stop_test();
   end
endmodule
